//--- hdl/sarr_pkg.sv
// Constants shared by the serial converter readout block
// Contract
// - Frame select falling low starts a new conversion.
// - Frame select low bounds the transfer; the host holds it low throughout.
// - Serial result output changes only on serial clock falling edges or when frame select falls low.
// - Each frame sends four zeros, then twelve result bits MSB first.
// - Result is sent as plain unsigned binary, untransformed.
// - Approximation steps advance on the host serial clock only.
// - Output undriven while unselected; driven soon after frame select falls.
// - Output released after the final serial clock falling edge.
package sarr_pkg;
	localparam int RES_W = 12;
	localparam int CNT_W = 5;
	localparam int BUF_DEPTH = 2;
	localparam int SYNC_STAGES = 3;
	localparam int PIN_CS = 0;
	localparam int PIN_SCLK = 1;
	localparam logic [1:0] PIN_RST = 2'h3;
	localparam logic [CNT_W-1:0] FRAME_FALLS = 5'h10;
	localparam logic [CNT_W-1:0] FIRST_DATA_FALL = 5'h04;
	localparam logic [CNT_W-1:0] FIRST_DECIDE_RISE = 5'h03;
	localparam logic [CNT_W-1:0] LAST_DECIDE_RISE = 5'h0e;
	localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
	localparam logic [RES_W-1:0] CODE_START = 12'h800;
	localparam logic [RES_W-1:0] CODE_RST = 12'h000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_QUIET_NS = 60;
	localparam int QUIET_CYC = (T_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_DRIVE_MAX_NS = 20;
	localparam int DRIVE_CYC = (T_DRIVE_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : T_DRIVE_MAX_NS / CLK_PERIOD_NS;
	localparam int T_RELEASE_MAX_NS = 35;
	localparam int RELEASE_CYC = (T_RELEASE_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : T_RELEASE_MAX_NS / CLK_PERIOD_NS;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_CONV = 3'h2,
		ST_DONE = 3'h4
	} sarr_state_t;
endpackage

//--- hdl/sarr_buf_if.sv
// Valid/ready carrier for finished conversion results
`timescale 1ns/1ps
interface sarr_buf_if;
	import sarr_pkg::*;
	logic in_valid;
	logic in_ready;
	logic [RES_W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [RES_W-1:0] out_data;
	modport store (input in_valid, input in_data, input out_ready, output in_ready, output out_valid, output out_data);
	modport user (output in_valid, output in_data, output out_ready, input in_ready, input out_valid, input out_data);
endinterface

//--- hdl/sarr_buf.sv
// Two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps
module sarr_buf (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	sarr_buf_if.store bus
);
	import sarr_pkg::*;
	logic [RES_W-1:0] mem_q [BUF_DEPTH];
	logic [RES_W-1:0] mem_d [BUF_DEPTH];
	logic wr_q, wr_d, rd_q, rd_d;
	logic [1:0] cnt_q, cnt_d;
	logic push, pop;

	assign bus.in_ready = (cnt_q != 2'(BUF_DEPTH));
	assign bus.out_valid = (cnt_q != 2'h0);
	assign bus.out_data = mem_q[rd_q];

	always_comb begin
		push = bus.in_valid && bus.in_ready;
		pop = bus.out_valid && bus.out_ready;
		mem_d = mem_q;
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wr_q] = bus.in_data;
			wr_d = ~wr_q;
		end
		if (pop) begin
			rd_d = ~rd_q;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 2'h1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 2'h1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			for (int i = 0; i < BUF_DEPTH; i++) begin
				mem_q[i] <= CODE_RST;
			end
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			mem_q <= mem_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end
endmodule

//--- hdl/sarr_readout.sv
// Frame control, approximation sequencer and serial result shifter
`timescale 1ns/1ps
module sarr_readout (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_frame_sel_n,
	input wire logic i_serial_clk,
	input wire logic i_cmp_above,
	output logic [sarr_pkg::RES_W-1:0] o_dac_code,
	output logic o_hold,
	output logic o_serial_result_out,
	output logic o_serial_result_oe,
	output logic [sarr_pkg::RES_W-1:0] o_result_data,
	output logic o_result_valid,
	input wire logic i_result_ready
);
	import sarr_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: a change counts once stages two and three agree
	logic [1:0] sync_q [SYNC_STAGES];
	logic [1:0] sync_d [SYNC_STAGES];
	logic [1:0] pin_q, pin_d;
	logic cs_fall, cs_rise, sclk_fall, sclk_rise;

	always_comb begin
		sync_d[0] = {i_serial_clk, i_frame_sel_n};
		for (int i = 1; i < SYNC_STAGES; i++) begin
			sync_d[i] = sync_q[i-1];
		end
		pin_d = pin_q;
		for (int b = 0; b < 2; b++) begin
			if (sync_q[1][b] == sync_q[2][b]) begin
				pin_d[b] = sync_q[2][b];
			end
		end
		cs_fall = pin_q[PIN_CS] && !pin_d[PIN_CS];
		cs_rise = !pin_q[PIN_CS] && pin_d[PIN_CS];
		sclk_fall = pin_q[PIN_SCLK] && !pin_d[PIN_SCLK];
		sclk_rise = !pin_q[PIN_SCLK] && pin_d[PIN_SCLK];
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			for (int i = 0; i < SYNC_STAGES; i++) begin
				sync_q[i] <= PIN_RST;
			end
			pin_q <= PIN_RST;
		end else begin
			sync_q <= sync_d;
			pin_q <= pin_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Frame sequencer
	sarr_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [RES_W-1:0] code_q, code_d;
	logic sdo_q, sdo_d, oe_q, oe_d;
	logic done;
	logic [3:0] bit_idx;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		code_d = code_q;
		sdo_d = sdo_q;
		oe_d = oe_q;
		done = 1'b0;
		bit_idx = 4'(LAST_DECIDE_RISE - cnt_q);
		case (state_q)
			ST_IDLE: begin
				if (cs_fall) begin
					state_d = ST_CONV;
					cnt_d = CNT_RST;
					code_d = CODE_START;
					sdo_d = 1'b0;
					oe_d = 1'b1;
				end
			end
			ST_CONV: begin
				if (cs_rise) begin
					state_d = ST_IDLE;
					oe_d = 1'b0;
				end else if (sclk_fall) begin
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == FRAME_FALLS - 5'h01) begin
						state_d = ST_DONE;
						oe_d = 1'b0;
						sdo_d = 1'b0;
						done = 1'b1;
					end else if (cnt_q >= FIRST_DATA_FALL - 5'h01) begin
						sdo_d = code_q[bit_idx];
					end else begin
						sdo_d = 1'b0;
					end
				end else if (sclk_rise && cnt_q >= FIRST_DECIDE_RISE && cnt_q <= LAST_DECIDE_RISE) begin
					code_d[bit_idx] = i_cmp_above;
					if (bit_idx != 4'h0) begin
						code_d[4'(bit_idx - 4'h1)] = 1'b1;
					end
				end
			end
			ST_DONE: begin
				if (cs_rise) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
				oe_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			state_q <= ST_IDLE;
			cnt_q <= CNT_RST;
			code_q <= CODE_RST;
			sdo_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			code_q <= code_d;
			sdo_q <= sdo_d;
			oe_q <= oe_d;
		end
	end

	assign o_dac_code = code_q;
	assign o_hold = (state_q == ST_CONV);
	assign o_serial_result_out = sdo_q;
	assign o_serial_result_oe = oe_q;

	////////////////////////////////////////////////////////////////////////////
	// Finished results wait here until the buffer has room
	// A new result while the buffer is still full replaces the one waiting here
	// The host cannot be stalled, so the newest conversion is kept over the earlier one waiting here
	logic pend_valid_q, pend_valid_d;
	logic [RES_W-1:0] pend_data_q, pend_data_d;
	sarr_buf_if rbuf ();

	always_comb begin
		pend_valid_d = pend_valid_q;
		pend_data_d = pend_data_q;
		if (done) begin
			pend_valid_d = 1'b1;
			pend_data_d = code_q;
		end else if (rbuf.in_ready) begin
			pend_valid_d = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			pend_valid_q <= 1'b0;
			pend_data_q <= CODE_RST;
		end else begin
			pend_valid_q <= pend_valid_d;
			pend_data_q <= pend_data_d;
		end
	end

	assign rbuf.in_valid = pend_valid_q;
	assign rbuf.in_data = pend_data_q;
	assign rbuf.out_ready = i_result_ready;
	assign o_result_valid = rbuf.out_valid;
	assign o_result_data = rbuf.out_data;

	sarr_buf u_buf (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.bus(rbuf.store)
	);

	////////////////////////////////////////////////////////////////////////////
	// Checks
	localparam int chk_drive_lim = DRIVE_CYC;
	localparam int chk_release_lim = RELEASE_CYC;
	logic [3:0] chk_out_idx;
	assign chk_out_idx = 4'(5'h0f - cnt_q);

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_sys_rst);

	sequence seq_start;
		state_q == ST_IDLE && cs_fall;
	endsequence
	sequence seq_last_fall;
		state_q == ST_CONV && !cs_rise && sclk_fall && cnt_q == 5'h0f;
	endsequence

	chk_start_conv: assert property (seq_start |=> state_q == ST_CONV && code_q == CODE_START && cnt_q == CNT_RST)
		else $error("conversion not started by frame select fall");
	chk_frame_bound: assert property (state_q == ST_CONV && cs_rise |=> state_q == ST_IDLE && !o_serial_result_oe)
		else $error("frame not ended by frame select rise");
	chk_fall_update: assert property ($changed(o_serial_result_out) |-> $past(sclk_fall) || $past(cs_fall))
		else $error("serial output changed without a falling edge");
	chk_lead_zeros: assert property (o_serial_result_oe && cnt_q < FIRST_DATA_FALL |-> !o_serial_result_out)
		else $error("leading bit not zero");
	chk_data_order: assert property (o_serial_result_oe && cnt_q >= FIRST_DATA_FALL |-> o_serial_result_out == code_q[chk_out_idx])
		else $error("result bit out of order");
	chk_plain_code: assert property (seq_last_fall |=> pend_valid_q && pend_data_q == $past(code_q))
		else $error("stored result differs from conversion code");
	chk_sar_clocked: assert property (state_q == ST_CONV && !sclk_rise |=> $stable(code_q))
		else $error("approximation moved without a serial clock rise");
	chk_sar_decide: assert property (state_q == ST_CONV && !cs_rise && sclk_rise && cnt_q == FIRST_DECIDE_RISE
		|=> code_q[RES_W-1] == $past(i_cmp_above) && code_q[RES_W-2])
		else $error("most significant decision not taken");
	chk_drive_start: assert property (seq_start |-> ##[1:chk_drive_lim] o_serial_result_oe)
		else $error("output not driven after frame select fall");
	chk_idle_float: assert property (pin_q[PIN_CS] && state_q != ST_CONV |-> !o_serial_result_oe)
		else $error("output driven while not selected");
	chk_release: assert property (seq_last_fall |-> ##[1:chk_release_lim] !o_serial_result_oe ##1 !o_serial_result_oe)
		else $error("output not released after final falling edge");
	chk_hold_start: assert property (seq_start |=> o_hold)
		else $error("hold not raised at conversion start");
	chk_hold_end: assert property (seq_last_fall |=> !o_hold)
		else $error("hold still raised after the sixteenth falling edge");
endmodule

//--- verif/sarr_host_model.sv
// Serial master model that frames conversions and reads results
`timescale 1ns/1ps
module sarr_host_model (
	input wire logic i_core_clk,
	input wire logic i_sdo,
	input wire logic i_sdo_oe,
	output logic o_frame_sel_n,
	output logic o_serial_clk
);
	import sarr_pkg::*;
	int oe_lost = 0;
	initial begin
		o_frame_sel_n = 1'b1;
		o_serial_clk = 1'b1;
	end
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Serial clock stands high outside frames, 80 ns period inside
	task automatic frame(input int n_clk, output logic [15:0] word, output logic released);
		word = 16'h0000;
		o_frame_sel_n <= 1'b0;
		wait_cyc(8);
		for (int i = 0; i < n_clk; i++) begin
			if (i_sdo_oe !== 1'b1) begin
				oe_lost++;
			end
			word = {word[14:0], i_sdo};
			o_serial_clk <= 1'b0;
			wait_cyc(4);
			o_serial_clk <= 1'b1;
			wait_cyc(4);
		end
		wait_cyc(4);
		released = !i_sdo_oe;
		o_frame_sel_n <= 1'b1;
		wait_cyc(QUIET_CYC + 4);
	endtask
endmodule

//--- verif/tb.sv
// Self-checking bench for the serial converter readout block
`timescale 1ns/1ps
module tb;
	import sarr_pkg::*;
	typedef struct {logic [11:0] vin; logic [15:0] word;} sarr_row_t;
	logic i_core_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic cmp_above = 1'b0;
	logic result_ready = 1'b0;
	logic [11:0] vin = 12'h000;
	logic fsel_n;
	logic sclk;
	logic [11:0] dac_code;
	logic hold;
	logic sdo;
	logic sdo_oe;
	logic sdo_last = 1'b0;
	logic sdo_wire;
	logic [11:0] result_data;
	logic result_valid;
	logic [15:0] word;
	logic rel;
	int failures = 0;
	int n_compared = 0;
	int hold_cyc = 0;
	int hc;
	sarr_row_t rows [7] = '{'{12'h000, 16'h0000}, '{12'hfff, 16'h0fff}, '{12'h800, 16'h0800},
		'{12'h7ff, 16'h07ff}, '{12'ha5c, 16'h0a5c}, '{12'h001, 16'h0001}, '{12'h555, 16'h0555}};
	always #5 i_core_clk = ~i_core_clk;
	// Comparator and released data line as seen by the far side
	always @(posedge i_core_clk) cmp_above <= (vin >= dac_code);
	always @(posedge i_core_clk) if (sdo_oe) sdo_last <= sdo;
	always @(posedge i_core_clk) if (hold) hold_cyc <= hold_cyc + 1;
	assign sdo_wire = sdo_oe ? sdo : ~sdo_last;
	sarr_readout i_sarr_readout (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_frame_sel_n(fsel_n),
		.i_serial_clk(sclk), .i_cmp_above(cmp_above), .o_dac_code(dac_code), .o_hold(hold),
		.o_serial_result_out(sdo), .o_serial_result_oe(sdo_oe), .o_result_data(result_data),
		.o_result_valid(result_valid), .i_result_ready(result_ready));
	sarr_host_model u_host (.i_core_clk(i_core_clk), .i_sdo(sdo_wire), .i_sdo_oe(sdo_oe),
		.o_frame_sel_n(fsel_n), .o_serial_clk(sclk));
	////////////////////////////////////////////////////////////////////////
	task automatic cmp_bit(input string name, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %b, seen %b", name, exp, got);
		end
	endtask
	task automatic cmp_word(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task automatic pop(input logic [15:0] exp);
		int n;
		n = 0;
		while (result_valid !== 1'b1 && n < 50) begin
			@(posedge i_core_clk);
			n++;
		end
		cmp_bit("result valid", 1'b1, result_valid);
		cmp_word("result", exp, {4'h0, result_data});
		result_ready <= 1'b1;
		@(posedge i_core_clk);
		result_ready <= 1'b0;
		@(posedge i_core_clk);
	endtask
	task automatic end_sim;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_core_clk);
		cmp_bit("oe", 1'b0, sdo_oe);
		cmp_bit("valid", 1'b0, result_valid);
		cmp_bit("hold", 1'b0, hold);
		cmp_word("dac", 16'h0000, {4'h0, dac_code});
		repeat (5) @(posedge i_core_clk);
		foreach (rows[i]) begin
			vin <= rows[i].vin;
			hc = hold_cyc;
			u_host.frame(16, word, rel);
			cmp_word("frame", rows[i].word, word);
			// Sixteen serial clock periods of eight core cycles each
			cmp_word("hold cycles", 16'h0080, 16'(hold_cyc - hc));
			cmp_bit("hold end", 1'b0, hold);
			cmp_bit("release", 1'b1, rel);
			pop(rows[i].word);
		end
		cmp_word("oe lost", 16'h0000, 16'(u_host.oe_lost));
		// Deselect after eight clocks: nothing stored, line released
		vin <= 12'h3c3;
		u_host.frame(8, word, rel);
		cmp_bit("abort valid", 1'b0, result_valid);
		cmp_bit("abort oe", 1'b0, sdo_oe);
		// Consumer stalls over three frames, then drains in order
		for (int i = 0; i < 3; i++) begin
			vin <= rows[i + 4].vin;
			u_host.frame(16, word, rel);
			cmp_word("stall frame", rows[i + 4].word, word);
		end
		for (int i = 0; i < 3; i++) begin
			pop(rows[i + 4].word);
		end
		cmp_bit("drained", 1'b0, result_valid);
		// Reset in mid-run with a result waiting, then one clean frame
		vin <= 12'h3c3;
		u_host.frame(16, word, rel);
		cmp_word("pre reset frame", 16'h03c3, word);
		i_sys_rst <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_core_clk);
		cmp_bit("reset valid", 1'b0, result_valid);
		cmp_bit("reset oe", 1'b0, sdo_oe);
		cmp_bit("reset hold", 1'b0, hold);
		cmp_word("reset dac", 16'h0000, {4'h0, dac_code});
		repeat (5) @(posedge i_core_clk);
		vin <= rows[1].vin;
		u_host.frame(16, word, rel);
		cmp_word("after reset", rows[1].word, word);
		cmp_bit("after reset release", 1'b1, rel);
		pop(rows[1].word);
		end_sim();
	end
	initial begin
		#100us;
		failures++;
		end_sim();
	end
endmodule
